/* File: verilog/fbc_pkg.sv */
// package for the flash bus host controller: commands, timings, request kinds
// assumes a 125 MHz clock_in; all pin timing derived from it
`default_nettype none
package fbc_pkg;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          ADDR_W          = 20;
    localparam int          DATA_W          = 8;
    // command codes
    localparam logic [7:0]  CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0]  CMD_IDENT       = 8'h90;
    localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
    localparam logic [7:0]  CMD_CLR_STATUS  = 8'h50;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0]  CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0]  CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0]  CMD_WRITE_ALT   = 8'h10;
    localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
    // identifier addresses
    localparam logic [19:0] ID_MFR_ADDR     = 20'h00000;
    localparam logic [19:0] ID_DEV_ADDR     = 20'h00001;
    // pin timing in ns, and cycle counts (least times round up)
    localparam int          STROBE_NS       = 50;
    localparam int          ACCESS_NS       = 90;
    localparam int          RECOVER_NS      = 30;
    localparam int          WAKE_READ_NS    = 400;
    localparam int          WAKE_WRITE_NS   = 1000;
    localparam int          STROBE_CYC      =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ACCESS_CYC      =
        (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RECOVER_CYC     =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_READ_CYC   =
        (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_WRITE_CYC  =
        (WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 8;
    // host request kinds
    typedef enum logic [2:0] {
        FBC_OP_READ_ARRAY,
        FBC_OP_READ_ID,
        FBC_OP_READ_STATUS,
        FBC_OP_CLR_STATUS,
        FBC_OP_ERASE,
        FBC_OP_WRITE_BYTE,
        FBC_OP_SUSPEND,
        FBC_OP_RESUME
    } fbc_op_t;
endpackage
`default_nettype wire

/* File: verilog/fbc_pin_if.sv */
// interface carrying one pin cycle request between sequencer and timer
// assumes both ends on clock_in
`default_nettype none
interface fbc_pin_if;
    logic       start;
    logic       is_write;
    logic       done;
    modport seq   (output start, output is_write, input done);
    modport timer (input start, input is_write, output done);
endinterface
`default_nettype wire

/* File: verilog/fbc_pin_timer.sv */
// timer for one strobe cycle: strobe phase then recovery phase
// assumes start is a one-cycle pulse given only while idle
`default_nettype none
module fbc_pin_timer
    import fbc_pkg::*;
(
    // clock and reset
    input  wire logic   clock_in,
    input  wire logic   reset_in,
    // request side
    fbc_pin_if.timer    pin,
    // strobe phase indicator and one-cycle sample pulse
    output logic        strobe_out,
    output logic        sample_out
);
    logic [CNT_W-1:0] cnt_q;
    logic             rec_q;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_q      <= '0;
            strobe_out <= 1'b0;
            rec_q      <= 1'b0;
            pin.done   <= 1'b0;
            sample_out <= 1'b0;
        end else begin
            pin.done   <= 1'b0;
            sample_out <= 1'b0;
            if (pin.start) begin
                strobe_out <= 1'b1;
                cnt_q <= pin.is_write ? CNT_W'(STROBE_CYC)
                                      : CNT_W'(ACCESS_CYC);
            end else if (cnt_q > 1) begin
                cnt_q <= cnt_q - 1'b1;
            end else if (strobe_out) begin
                // data sampled on the last strobe cycle, before release
                sample_out <= 1'b1;
                strobe_out <= 1'b0;
                rec_q      <= 1'b1;
                cnt_q      <= CNT_W'(RECOVER_CYC);
            end else if (rec_q) begin
                rec_q    <= 1'b0;
                pin.done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/fbc_host.sv */
// host controller driving a parallel block-erase flash over its pins
// assumes pins are synchronous to clock_in; one request at a time
// Contract
// - read mode chosen by command first
// - read: select and output enable low
// - never both enables low together
// - wait wake delay before reading
// - wait wake delay before writing
// - identifier: address selects maker/device
// - write latched on strobe rising edge
// - FFH selects array read
`default_nettype none
module fbc_host
    import fbc_pkg::*;
#(
    parameter int WAKE_WRITE_CYCLES = WAKE_WRITE_CYC,
    parameter int WAKE_READ_CYCLES  = WAKE_READ_CYC
) (
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    // user request
    input  wire logic              req_valid_in,
    input  wire fbc_op_t           req_op_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_data_in,
    input  wire logic              powerdown_req_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output logic [DATA_W-1:0]      rsp_data_out,
    output logic                   busy_out,
    // flash pins
    output logic                   reset_powerdown_n_out,
    output logic                   chip_select_n_out,
    output logic                   output_enable_n_out,
    output logic                   write_strobe_n_out,
    output logic [ADDR_W-1:0]      address_out,
    output logic [DATA_W-1:0]      data_io_out,
    output logic                   data_io_oe_out,
    input  wire logic [DATA_W-1:0] data_io_in,
    input  wire logic              ready_busy_n_in
);
    typedef enum logic [2:0] {
        FBC_ST_DOWN, FBC_ST_WAKE, FBC_ST_IDLE, FBC_ST_CYC1,
        FBC_ST_CYC2, FBC_ST_WAIT_BUSY
    } fbc_state_t;

    fbc_state_t        state_q;
    fbc_op_t           op_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] cmd2_q;
    logic [11:0]       wake_q;
    logic              start_q;
    logic              is_wr_q;
    logic              strobe;
    logic              sample;
    logic              pin_act;
    fbc_pin_if         pin ();

    assign pin.start    = start_q;
    assign pin.is_write = is_wr_q;

    // strobes only inside a bus cycle: a cycle cut by powerdown must not
    // leave an enable low while the part sleeps or wakes
    assign pin_act = strobe && !powerdown_req_in
                     && (state_q == FBC_ST_CYC1 || state_q == FBC_ST_CYC2);

    fbc_pin_timer u_timer (
        .clock_in   (clock_in),
        .reset_in   (reset_in),
        .pin        (pin),
        .strobe_out (strobe),
        .sample_out (sample)
    );

    // first-cycle command for each request kind
    function automatic logic [7:0] first_cmd(input fbc_op_t op);
        case (op)
            FBC_OP_READ_ARRAY:  first_cmd = CMD_READ_ARRAY;
            FBC_OP_READ_ID:     first_cmd = CMD_IDENT;
            FBC_OP_READ_STATUS: first_cmd = CMD_READ_STATUS;
            FBC_OP_CLR_STATUS:  first_cmd = CMD_CLR_STATUS;
            FBC_OP_ERASE:       first_cmd = CMD_ERASE_SETUP;
            FBC_OP_WRITE_BYTE:  first_cmd = CMD_WRITE_SETUP;
            FBC_OP_SUSPEND:     first_cmd = CMD_SUSPEND;
            FBC_OP_RESUME:      first_cmd = CMD_CONFIRM;
            default:            first_cmd = CMD_READ_ARRAY;
        endcase
    endfunction

    // ops that go on to a second cycle (read or write)
    function automatic logic has_second(input fbc_op_t op);
        has_second = (op == FBC_OP_READ_ARRAY) || (op == FBC_OP_READ_ID)
                  || (op == FBC_OP_READ_STATUS) || (op == FBC_OP_ERASE)
                  || (op == FBC_OP_WRITE_BYTE);
    endfunction

    function automatic logic alters(input fbc_op_t op);
        alters = (op == FBC_OP_ERASE) || (op == FBC_OP_WRITE_BYTE)
              || (op == FBC_OP_RESUME);
    endfunction

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_q       <= FBC_ST_DOWN;
            op_q          <= FBC_OP_READ_ARRAY;
            data_q        <= '0;
            cmd2_q        <= '0;
            wake_q        <= '0;
            start_q       <= 1'b0;
            is_wr_q       <= 1'b0;
            req_ready_out <= 1'b0;
            address_out   <= '0;
        end else begin
            start_q       <= 1'b0;
            req_ready_out <= 1'b0;
            case (state_q)
                FBC_ST_DOWN: begin
                    wake_q <= '0;
                    if (!powerdown_req_in) begin
                        state_q <= FBC_ST_WAKE;
                    end
                end
                FBC_ST_WAKE: begin
                    wake_q <= wake_q + 1'b1;
                    if (32'(wake_q) + 1 >= WAKE_WRITE_CYCLES &&
                        32'(wake_q) + 1 >= WAKE_READ_CYCLES) begin
                        state_q       <= FBC_ST_IDLE;
                        req_ready_out <= 1'b1;
                    end
                end
                FBC_ST_IDLE: begin
                    req_ready_out <= 1'b1;
                    // no new setup while device busy
                    if (req_valid_in && ready_busy_n_in) begin
                        req_ready_out <= 1'b0;
                        op_q        <= req_op_in;
                        data_q      <= req_data_in;
                        address_out <= req_addr_in;
                        cmd2_q      <= first_cmd(req_op_in);
                        is_wr_q     <= 1'b1;
                        start_q     <= 1'b1;
                        state_q     <= FBC_ST_CYC1;
                    end
                end
                FBC_ST_CYC1: begin
                    if (pin.done) begin
                        if (has_second(op_q)) begin
                            if (op_q == FBC_OP_ERASE) begin
                                cmd2_q <= CMD_CONFIRM;
                            end else if (op_q == FBC_OP_WRITE_BYTE) begin
                                cmd2_q <= data_q;
                            end
                            is_wr_q <= (op_q == FBC_OP_ERASE)
                                    || (op_q == FBC_OP_WRITE_BYTE);
                            start_q <= 1'b1;
                            state_q <= FBC_ST_CYC2;
                        end else begin
                            state_q <= FBC_ST_IDLE;
                        end
                    end
                end
                FBC_ST_CYC2: begin
                    if (pin.done) begin
                        state_q <= alters(op_q) ? FBC_ST_WAIT_BUSY
                                                : FBC_ST_IDLE;
                    end
                end
                // device reports completion by ready high
                FBC_ST_WAIT_BUSY: begin
                    if (ready_busy_n_in) begin
                        state_q <= FBC_ST_IDLE;
                    end
                end
                default: state_q <= FBC_ST_DOWN;
            endcase
            if (powerdown_req_in) begin
                state_q       <= FBC_ST_DOWN;
                req_ready_out <= 1'b0;
                start_q       <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // pins
    // --------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reset_powerdown_n_out <= 1'b0;
            chip_select_n_out     <= 1'b1;
            output_enable_n_out   <= 1'b1;
            write_strobe_n_out    <= 1'b1;
            data_io_out           <= '0;
            data_io_oe_out        <= 1'b0;
        end else begin
            reset_powerdown_n_out <= !(state_q == FBC_ST_DOWN
                                       || powerdown_req_in);
            chip_select_n_out     <= !pin_act;
            // only one enable low at a time
            // strobe release latches address and data
            write_strobe_n_out    <= !(pin_act && is_wr_q);
            output_enable_n_out   <= !(pin_act && !is_wr_q);
            data_io_oe_out        <= pin_act && is_wr_q;
            data_io_out           <= cmd2_q;
        end
    end

    // --------------------------------------------------------------
    // response
    // --------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= '0;
            busy_out      <= 1'b0;
        end else begin
            rsp_valid_out <= sample && !is_wr_q && state_q == FBC_ST_CYC2;
            if (sample && !is_wr_q) begin
                rsp_data_out <= data_io_in;
            end
            busy_out <= !ready_busy_n_in || state_q != FBC_ST_IDLE;
        end
    end
endmodule
`default_nettype wire

/* File: verification/fbc_host_assertions.sv */
// checker for the flash host controller, bound into fbc_host
// assumes it sees only the top module's ports
`default_nettype none
module fbc_host_assertions #(
    parameter int WAKE_WRITE_CYCLES = 2,
    parameter int WAKE_READ_CYCLES  = 2
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic powerdown_req_in,
    input wire logic ready_busy_n_in,
    input wire logic busy_out,
    input wire logic rsp_valid_out,
    input wire logic reset_powerdown_n_out,
    input wire logic chip_select_n_out,
    input wire logic output_enable_n_out,
    input wire logic write_strobe_n_out,
    input wire logic data_io_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wake_q;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // cycles with the powerdown pin high, saturating
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in || !reset_powerdown_n_out) wake_q <= 8'h00;
        else if (wake_q != 8'hFF) wake_q <= wake_q + 8'h01;
    end
    // ------------------------------------------------------------
    // pin rules
    // ------------------------------------------------------------
    a_no_both_low: assert property (
        output_enable_n_out || write_strobe_n_out)
        else $error("both enables low");
    a_read_no_drive: assert property (
        !output_enable_n_out |-> !data_io_oe_out)
        else $error("host drives data during read");
    a_pd_quiet: assert property (
        !reset_powerdown_n_out |-> chip_select_n_out && write_strobe_n_out)
        else $error("strobes active in powerdown");
    a_pd_follow: assert property (
        powerdown_req_in |-> ##[1:3] !reset_powerdown_n_out)
        else $error("powerdown pin not lowered");
    a_wake_write: assert property (
        $fell(write_strobe_n_out) |-> wake_q >= WAKE_WRITE_CYCLES)
        else $error("write too soon after wake");
    a_wake_read: assert property (
        $fell(output_enable_n_out) |-> wake_q >= WAKE_READ_CYCLES)
        else $error("read too soon after wake");
    a_strobe_held: assert property (
        $fell(write_strobe_n_out)
        |-> (!chip_select_n_out && data_io_oe_out)[*7])
        else $error("write cycle cut short");
    a_busy_flag: assert property (
        !ready_busy_n_in |=> busy_out)
        else $error("busy not reported");
    a_busy_no_cmd: assert property (
        !ready_busy_n_in |=> write_strobe_n_out)
        else $error("command written to busy device");
    a_rsp_pulse: assert property (
        rsp_valid_out |=> !rsp_valid_out)
        else $error("response longer than one cycle");
    c_write: cover property ($fell(write_strobe_n_out));
    c_read: cover property ($fell(output_enable_n_out));
    c_abort: cover property (!ready_busy_n_in && powerdown_req_in);
endmodule
bind fbc_host fbc_host_assertions #(
    .WAKE_WRITE_CYCLES(WAKE_WRITE_CYCLES),
    .WAKE_READ_CYCLES (WAKE_READ_CYCLES)
) i_chk (.clock_in, .reset_in, .powerdown_req_in, .ready_busy_n_in,
    .busy_out, .rsp_valid_out, .reset_powerdown_n_out, .chip_select_n_out,
    .output_enable_n_out, .write_strobe_n_out, .data_io_oe_out);
`default_nettype wire

/* File: verification/fbc_flash_model.sv */
// behavioural model of the flash part at its pins
// assumes pins are sampled on the host clock; data_in is the resolved bus
`default_nettype none
module fbc_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary value
    parameter int         BUSY_CYC = 20
) (
    input  wire logic        clock_in,
    input  wire logic        reset_powerdown_n_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        output_enable_n_in,
    input  wire logic        write_strobe_n_in,
    input  wire logic [19:0] address_in,
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             ready_busy_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [16];
    logic [7:0] sr_q;
    logic [7:0] rd;
    logic [7:0] last_q = 8'h00;
    logic [1:0] mode_q;
    logic [1:0] setup_q;
    logic       we_q;
    logic       cs_q;
    logic [7:0] din_q;
    logic [3:0] adr_q;
    logic       drive;
    int         busy_q;
    // busy runs on even when deselected
    assign ready_busy_n_out = (busy_q == 0);
    // drive only for a selected read
    assign drive = reset_powerdown_n_in && !chip_select_n_in
                   && !output_enable_n_in && write_strobe_n_in;
    always_comb begin
        case (mode_q)
            2'd1: rd = address_in[0] ? DEV_CODE : MFR_CODE;
            2'd2: rd = {ready_busy_n_out, sr_q[6:0]};
            default: rd = mem_q[address_in[3:0]];
        endcase
    end
    // a released bus must not look like stale valid data
    assign data_out = drive ? rd : ~last_q;
    always @(posedge clock_in) begin
        // select, address and data as they stood while the strobe was low:
        // the host drops select and data on the same edge that raises the strobe
        we_q <= write_strobe_n_in;
        cs_q <= chip_select_n_in;
        din_q <= data_in;
        adr_q <= address_in[3:0];
        if (drive) last_q <= rd;
        if (!reset_powerdown_n_in) begin
            mode_q <= 2'd0;
            setup_q <= 2'd0;
            busy_q <= 0;
            sr_q <= 8'h80;
        end else begin
            if (busy_q > 0) busy_q <= busy_q - 1;
            // latch on strobe rise, ignore while busy
            if (write_strobe_n_in && !we_q && !cs_q
                && busy_q == 0) begin
                setup_q <= 2'd0;
                if (setup_q != 2'd0) begin
                    mode_q <= 2'd2;
                    busy_q <= BUSY_CYC;
                    if (setup_q == 2'd2) mem_q[adr_q] <= din_q;
                    else if (din_q == 8'hD0)
                        foreach (mem_q[i]) mem_q[i] <= 8'hFF;
                    else busy_q <= 0;
                end else begin
                    case (din_q)
                        8'hFF: mode_q <= 2'd0;
                        8'h90: mode_q <= 2'd1;
                        8'h70: mode_q <= 2'd2;
                        8'h50: sr_q <= 8'h80;
                        8'h20: setup_q <= 2'd1;
                        8'h40, 8'h10: setup_q <= 2'd2;
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench: fbc_host against the flash model
// assumes the checker binds itself into fbc_host
`default_nettype none
module tb_top
    import fbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        fbc_op_t op; logic [19:0] a; logic [7:0] d; logic [7:0] e; logic c;
    } fbc_row_t;
    logic clock_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0;
    logic powerdown_req_in = 1'b0;
    fbc_op_t req_op_in = FBC_OP_READ_ARRAY;
    logic [19:0] req_addr_in = 20'h00000;
    logic [7:0]  req_data_in = 8'h00, data_io_in, data_io_out, dev, got;
    logic req_ready_out, rsp_valid_out, busy_out, reset_powerdown_n_out;
    logic chip_select_n_out, output_enable_n_out, write_strobe_n_out;
    logic data_io_oe_out, ready_busy_n_in;
    logic [19:0] address_out;
    logic [7:0]  rsp_data_out;
    fbc_row_t rows [11];
    int error_cnt = 0, compares = 0;
    always #4 clock_in = ~clock_in;
    assign data_io_in = data_io_oe_out ? data_io_out : dev;
    fbc_host #(.WAKE_WRITE_CYCLES(6), .WAKE_READ_CYCLES(4)) i_dut (
        .clock_in, .reset_in, .req_valid_in, .req_op_in, .req_addr_in,
        .req_data_in, .powerdown_req_in, .req_ready_out, .rsp_valid_out,
        .rsp_data_out, .busy_out, .reset_powerdown_n_out, .chip_select_n_out,
        .output_enable_n_out, .write_strobe_n_out, .address_out,
        .data_io_out, .data_io_oe_out, .data_io_in, .ready_busy_n_in);
    fbc_flash_model i_flash (.clock_in,
        .reset_powerdown_n_in(reset_powerdown_n_out),
        .chip_select_n_in(chip_select_n_out),
        .output_enable_n_in(output_enable_n_out),
        .write_strobe_n_in(write_strobe_n_out), .address_in(address_out),
        .data_in(data_io_in), .data_out(dev),
        .ready_busy_n_out(ready_busy_n_in));
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 3000; n++) begin
            @(negedge clock_in);
            if (req_ready_out === 1'b1 && busy_out === 1'b0) break;
        end
        if (n == 3000) begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic issue(input fbc_op_t op, input logic [19:0] a,
                         input logic [7:0] d, output logic [7:0] res);
        int n;
        res = 8'hXX;
        wait_idle();
        @(posedge clock_in);
        req_op_in <= op;
        req_addr_in <= a;
        req_data_in <= d;
        req_valid_in <= 1'b1;
        @(posedge clock_in);
        req_valid_in <= 1'b0;
        repeat (2) @(negedge clock_in);
        for (n = 0; n < 3000; n++) begin
            @(negedge clock_in);
            if (rsp_valid_out === 1'b1) res = rsp_data_out;
            if (req_ready_out === 1'b1 && busy_out === 1'b0) break;
        end
        if (n == 3000) begin
            error_cnt++;
            conclude();
        end
    endtask
    initial begin
        rows[0] = '{FBC_OP_WRITE_BYTE, 20'h00005, 8'hA5, 8'h00, 1'b0};
        rows[1] = '{FBC_OP_READ_ARRAY, 20'h00005, 8'h00, 8'hA5, 1'b1};
        rows[2] = '{FBC_OP_READ_STATUS, 20'h00000, 8'h00, 8'h80, 1'b1};
        rows[3] = '{FBC_OP_READ_ID, 20'h00000, 8'h00, 8'h5A, 1'b1};
        rows[4] = '{FBC_OP_READ_ID, 20'h00001, 8'h00, 8'hC3, 1'b1};
        rows[5] = '{FBC_OP_ERASE, 20'h00005, 8'h00, 8'h00, 1'b0};
        rows[6] = '{FBC_OP_READ_ARRAY, 20'h00005, 8'h00, 8'hFF, 1'b1};
        rows[7] = '{FBC_OP_CLR_STATUS, 20'h00000, 8'h00, 8'h00, 1'b0};
        rows[8] = '{FBC_OP_SUSPEND, 20'h00000, 8'h00, 8'h00, 1'b0};
        rows[9] = '{FBC_OP_RESUME, 20'h00000, 8'h00, 8'h00, 1'b0};
        rows[10] = '{FBC_OP_READ_ARRAY, 20'h00005, 8'h00, 8'hFF, 1'b1};
        repeat (5) @(negedge clock_in);
        check("pd_pin", {7'h00, reset_powerdown_n_out}, 8'h00);
        check("we_pin", {7'h00, write_strobe_n_out}, 8'h01);
        repeat (5) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            issue(rows[i].op, rows[i].a, rows[i].d, got);
            if (rows[i].c) check($sformatf("row%0d", i), got, rows[i].e);
        end
        // ------------------------------------------------------------
        // refused request and abort during a byte write
        // ------------------------------------------------------------
        wait_idle();
        @(posedge clock_in);
        req_op_in <= FBC_OP_WRITE_BYTE;
        req_data_in <= 8'h3C;
        req_valid_in <= 1'b1;
        @(posedge clock_in);
        req_op_in <= FBC_OP_READ_ID;
        for (int n = 0; n < 200 && ready_busy_n_in !== 1'b0; n++)
            @(negedge clock_in);
        check("busy_seen", {7'h00, ready_busy_n_in}, 8'h00);
        check("ready_busy", {7'h00, req_ready_out}, 8'h00);
        @(posedge clock_in);
        req_valid_in <= 1'b0;
        powerdown_req_in <= 1'b1;
        repeat (4) @(negedge clock_in);
        check("rb_pd", {7'h00, ready_busy_n_in}, 8'h01);
        check("oe_pd", {7'h00, data_io_oe_out}, 8'h00);
        @(posedge clock_in);
        powerdown_req_in <= 1'b0;
        issue(FBC_OP_READ_STATUS, 20'h00000, 8'h00, got);
        check("wake_status", got, 8'h80);
        conclude();
    end
endmodule
`default_nettype wire
